// ---- mif_src_model.sv ----
/*
 * source model: the other blocks that feed normalized values to the unit.
 * assumes one clock shared with the unit; values change after an edge.
 */
`timescale 1ns/1ps
`default_nettype none
module mif_src_model #(
  parameter int N = 16
) (
  input wire logic i_clk,
  output var mif_pkg::mif_val_t [N-1:0] o_val
);
  import mif_pkg::*;
  initial o_val = '0;
  // a new value lands on the next edge, like a same-clock producer
  task automatic put(input int idx, input mif_val_t v);
    @(posedge i_clk);
    o_val[idx] <= v;
  endtask
endmodule
`default_nettype wire

// ---- mif_stage.sv ----
/*
 * constants, types and the binary stage operator of the combining unit.
 * assumes one clock domain; values are signed fixed point, 24 fraction bits.
 */
// Contract
// - two independent four-input combining instances
// - per-channel source selector, zero means unconnected
// - per-channel invert flag, off after reset
// - per-channel scale coefficient, default one
// - stages two to four chain previous result
// - thirteen selectable operations, addition by default
// - unconnected later channels drop their stage
// - channel one or two open forces zero
// - output scale coefficient, default one
// - division raises both operands to delta
// - logical operands true at one half
// - comparisons with equality allow delta tolerance
`timescale 1ns/1ps
`default_nettype none
package mif_pkg;
  localparam int W = 32;
  localparam int FRAC = 24;
  localparam int SRC_W = 5;
  localparam int OP_W = 4;
  localparam int N_CH = 4;
  localparam int N_INST = 2;
  localparam int ADDR_W = 8;
  localparam int INST_BIT = 4;
  localparam int CFG_SRC_LSB = 0;
  localparam int CFG_INV_BIT = 8;
  localparam int CFG_OP_LSB = 12;
  localparam logic [3:0] REG_CFG0 = 4'h0;
  localparam logic [3:0] REG_SCALE0 = 4'h4;
  localparam logic [3:0] REG_OSCALE = 4'h8;
  localparam logic [3:0] REG_YN = 4'h9;
  localparam logic [3:0] REG_AVAIL = 4'ha;
  typedef logic signed [W-1:0] mif_val_t;
  localparam mif_val_t ONE = 32'sh0100_0000;
  localparam mif_val_t HALF = 32'sh0080_0000;
  // 1.0e-6 rounded up to the fraction grid
  localparam mif_val_t DELTA = 32'sh0000_0011;
  typedef enum logic [OP_W-1:0] {
    OP_ADD, OP_MUL, OP_DIV, OP_MAX, OP_MIN, OP_OR, OP_AND, OP_XOR,
    OP_LT, OP_LE, OP_EQ, OP_GT, OP_GE
  } mif_op_t;
  typedef struct packed {
    mif_op_t op;
    logic inv;
    logic [SRC_W-1:0] src;
  } mif_cfg_t;
  typedef struct packed {
    logic avail;
    mif_val_t normalized_output_value;
  } mif_out_t;
  localparam mif_cfg_t CFG_RST = '{op: OP_ADD, inv: 1'b0, src: '0};
  localparam mif_val_t SCALE_RST = ONE;

  function automatic mif_val_t mif_mul(input mif_val_t a, input mif_val_t b);
    logic signed [2*W-1:0] p;
    p = 64'(a) * 64'(b);
    return p[FRAC+W-1:FRAC];
  endfunction

  function automatic mif_val_t mif_clip(input mif_val_t v);
    return (v < 0) ? '0 : ((v > ONE) ? ONE : v);
  endfunction
endpackage

module mif_binop (
  // operation
  input wire mif_pkg::mif_op_t i_op,
  // operands
  input wire mif_pkg::mif_val_t i_x,
  input wire mif_pkg::mif_val_t i_y,
  // result
  output var mif_pkg::mif_val_t o_r
);
  import mif_pkg::*;
  mif_val_t xd, yd;
  logic signed [2*W-1:0] num, den, quo;
  logic xb, yb;
  always_comb begin
    xd = (i_x < DELTA) ? DELTA : i_x;
    yd = (i_y < DELTA) ? DELTA : i_y;
    num = 64'(xd) <<< FRAC;
    den = 64'(yd);
    quo = num / den;
    xb = (i_x >= HALF);
    yb = (i_y >= HALF);
  end
  always_comb begin
    unique case (i_op)
      OP_ADD: o_r = i_x + i_y;
      OP_MUL: o_r = mif_mul(i_x, i_y);
      OP_DIV: o_r = quo[W-1:0];
      OP_MAX: o_r = (i_x > i_y) ? i_x : i_y;
      OP_MIN: o_r = (i_x < i_y) ? i_x : i_y;
      OP_OR: o_r = (xb | yb) ? ONE : '0;
      OP_AND: o_r = (xb & yb) ? ONE : '0;
      OP_XOR: o_r = (xb ^ yb) ? ONE : '0;
      OP_LT: o_r = (i_x < i_y) ? ONE : '0;
      OP_LE: o_r = (i_x <= i_y + DELTA) ? ONE : '0;
      OP_EQ: o_r = ((i_x - i_y <= DELTA) && (i_y - i_x <= DELTA)) ?
                   ONE : '0;
      OP_GT: o_r = (i_x > i_y) ? ONE : '0;
      OP_GE: o_r = (i_x >= i_y - DELTA) ? ONE : '0;
      default: o_r = i_x;
    endcase
  end
endmodule
`default_nettype wire

// ---- mif_top.sv ----
/*
 * two-instance multi-input combining unit with a plain register port.
 * assumes sources come from logic on the same clock, already normalized.
 */
`timescale 1ns/1ps
`default_nettype none
module mif_top #(
  parameter int N_SRC = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // register port
  input wire logic [mif_pkg::ADDR_W-1:0] i_addr,
  input wire logic [mif_pkg::W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [mif_pkg::W-1:0] o_rdata,
  // source values from other blocks
  input wire mif_pkg::mif_val_t [N_SRC-1:0] i_normalized_input_value,
  // results
  output var mif_pkg::mif_out_t [mif_pkg::N_INST-1:0] o_out
);
  import mif_pkg::*;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  mif_cfg_t cfg_q [N_INST][N_CH];
  mif_val_t scale_q [N_INST][N_CH];
  mif_val_t oscale_q [N_INST];
  mif_val_t sc_q [N_INST][N_CH];
  logic conn_q [N_INST][N_CH];
  mif_out_t out_q [N_INST];
  logic [W-1:0] rdata_q;
  mif_val_t xsel_w [N_INST][N_CH];
  logic conn_w [N_INST][N_CH];
  mif_val_t f_w [N_INST][1:N_CH-1];
  mif_val_t res_w [N_INST][N_CH];

  logic sel_inst;
  logic [3:0] sel_idx;
  assign sel_inst = i_addr[INST_BIT];
  assign sel_idx = i_addr[3:0];

  // configuration writes
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int g = 0; g < N_INST; g++) begin
        oscale_q[g] <= SCALE_RST;
        for (int c = 0; c < N_CH; c++) begin
          cfg_q[g][c] <= CFG_RST;
          scale_q[g][c] <= SCALE_RST;
        end
      end
    end else if (i_wr) begin
      for (int c = 0; c < N_CH; c++) begin
        if (sel_idx == REG_CFG0 + 4'(c)) begin
          cfg_q[sel_inst][c].src <= i_wdata[CFG_SRC_LSB +: SRC_W];
          cfg_q[sel_inst][c].inv <= i_wdata[CFG_INV_BIT];
          cfg_q[sel_inst][c].op <= mif_op_t'(i_wdata[CFG_OP_LSB +: OP_W]);
        end
        if (sel_idx == REG_SCALE0 + 4'(c)) begin
          scale_q[sel_inst][c] <= i_wdata;
        end
      end
      if (sel_idx == REG_OSCALE) begin
        oscale_q[sel_inst] <= i_wdata;
      end
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= '0;
    end else if (i_rd) begin
      rdata_q <= '0;
      for (int c = 0; c < N_CH; c++) begin
        if (sel_idx == REG_CFG0 + 4'(c)) begin
          rdata_q[CFG_SRC_LSB +: SRC_W] <= cfg_q[sel_inst][c].src;
          rdata_q[CFG_INV_BIT] <= cfg_q[sel_inst][c].inv;
          rdata_q[CFG_OP_LSB +: OP_W] <= cfg_q[sel_inst][c].op;
        end
        if (sel_idx == REG_SCALE0 + 4'(c)) begin
          rdata_q <= scale_q[sel_inst][c];
        end
      end
      if (sel_idx == REG_OSCALE) begin
        rdata_q <= oscale_q[sel_inst];
      end
      if (sel_idx == REG_YN) begin
        rdata_q <= out_q[sel_inst].normalized_output_value;
      end
      if (sel_idx == REG_AVAIL) begin
        rdata_q <= W'(out_q[sel_inst].avail);
      end
    end
  end
  assign o_rdata = rdata_q;

  // source select; out-of-range codes count as unconnected
  always_comb begin
    for (int g = 0; g < N_INST; g++) begin
      for (int c = 0; c < N_CH; c++) begin
        conn_w[g][c] = (cfg_q[g][c].src != '0) &&
                       (int'(cfg_q[g][c].src) <= N_SRC);
        xsel_w[g][c] = conn_w[g][c] ?
          i_normalized_input_value[cfg_q[g][c].src - 5'h01] : '0;
      end
    end
  end

  // invert and scale each channel
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int g = 0; g < N_INST; g++) begin
        for (int c = 0; c < N_CH; c++) begin
          sc_q[g][c] <= '0;
          conn_q[g][c] <= 1'b0;
        end
      end
    end else begin
      for (int g = 0; g < N_INST; g++) begin
        for (int c = 0; c < N_CH; c++) begin
          sc_q[g][c] <= mif_mul(cfg_q[g][c].inv ?
            ONE - xsel_w[g][c] : xsel_w[g][c], scale_q[g][c]);
          conn_q[g][c] <= conn_w[g][c];
        end
      end
    end
  end

  // chained stages, two independent instances
  for (genvar g = 0; g < N_INST; g++) begin : g_inst
    assign res_w[g][0] = sc_q[g][0];
    for (genvar k = 1; k < N_CH; k++) begin : g_stage
      mif_binop u_op (
        .i_op(cfg_q[g][k].op),
        .i_x(res_w[g][k-1]),
        .i_y(sc_q[g][k]),
        .o_r(f_w[g][k])
      );
      assign res_w[g][k] = conn_q[g][k] ? f_w[g][k] : res_w[g][k-1];
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        out_q[g] <= '0;
      end else if (conn_q[g][0] && conn_q[g][1]) begin
        out_q[g].avail <= 1'b1;
        out_q[g].normalized_output_value <=
          mif_clip(mif_mul(res_w[g][N_CH-1], oscale_q[g]));
      end else begin
        out_q[g] <= '0;
      end
    end
    assign o_out[g] = out_q[g];

    AST_NC_ZERO: assert property (
      !(conn_w[g][0] && conn_w[g][1]) |=> ##1
        (!o_out[g].avail && o_out[g].normalized_output_value == '0))
      else $error("open input one or two did not zero output");

    AST_CLIP: assert property (
      o_out[g].normalized_output_value >= 0 &&
      o_out[g].normalized_output_value <= ONE)
      else $error("output left normalized range");

    AST_OUT_SCALE: assert property (
      (conn_q[g][0] && conn_q[g][1]) |=> o_out[g].normalized_output_value ==
        mif_clip(mif_mul($past(res_w[g][N_CH-1]), $past(oscale_q[g]))))
      else $error("output scale not applied");

    AST_INV_SCALE: assert property (
      (cfg_q[g][0].inv && conn_w[g][0]) |=> sc_q[g][0] ==
        mif_mul(ONE - $past(xsel_w[g][0]), $past(scale_q[g][0])))
      else $error("inverted channel value wrong");

    AST_SCALE: assert property (
      (!cfg_q[g][1].inv && conn_w[g][1]) |=> sc_q[g][1] ==
        mif_mul($past(xsel_w[g][1]), $past(scale_q[g][1])))
      else $error("channel scale wrong");

    AST_DROP: assert property (
      (conn_q[g][0] && conn_q[g][1] && !conn_q[g][2] && !conn_q[g][3] &&
       cfg_q[g][1].op == OP_ADD) |=> o_out[g].normalized_output_value ==
        mif_clip(mif_mul($past(sc_q[g][0]) + $past(sc_q[g][1]),
                         $past(oscale_q[g]))))
      else $error("unconnected stages not dropped");

    AST_CHAIN_ADD: assert property (
      (conn_q[g][3] && cfg_q[g][3].op == OP_ADD) |->
        res_w[g][3] == res_w[g][2] + sc_q[g][3])
      else $error("stage four did not chain");

    AST_DIV_FLOOR: assert property (
      (conn_q[g][1] && cfg_q[g][1].op == OP_DIV && sc_q[g][0] <= 0 &&
       sc_q[g][1] <= 0) |-> res_w[g][1] == ONE)
      else $error("division not guarded");

    AST_AND: assert property (
      (conn_q[g][1] && cfg_q[g][1].op == OP_AND) |-> res_w[g][1] ==
        ((sc_q[g][0] >= HALF && sc_q[g][1] >= HALF) ? ONE : '0))
      else $error("logical threshold wrong");

    AST_EQ_TOL: assert property (
      (conn_q[g][1] && cfg_q[g][1].op == OP_EQ &&
       sc_q[g][0] == sc_q[g][1] + DELTA) |-> res_w[g][1] == ONE)
      else $error("equality tolerance wrong");

    COV_AVAIL: cover property (@(posedge i_clk) disable iff (!i_rst_b)
      o_out[g].avail && o_out[g].normalized_output_value != '0);
    COV_FOUR: cover property (@(posedge i_clk) disable iff (!i_rst_b)
      conn_q[g][0] && conn_q[g][1] && conn_q[g][2] && conn_q[g][3]);
    COV_DIV: cover property (@(posedge i_clk) disable iff (!i_rst_b)
      conn_q[g][2] && cfg_q[g][2].op == OP_DIV);
  end
endmodule
`default_nettype wire

// ---- test_multi_input_function_unit.sv ----
/*
 * self-checking bench of the combining unit, both instances exercised.
 * assumes the register map and the two-cycle latency of the data path.
 */
`timescale 1ns/1ps
`default_nettype none
module test_multi_input_function_unit;
  import mif_pkg::*;
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, rv;
  mif_val_t [15:0] src;
  mif_out_t [1:0] o_out;
  int failures = 0, comparisons = 0;
  mif_val_t exp_op [13] = '{32'sh00c0_0000, 32'sh0020_0000, 32'sh0080_0000,
    32'sh0080_0000, 32'sh0040_0000, ONE, 32'sh0, ONE, ONE, ONE, 32'sh0,
    32'sh0, 32'sh0};
  always #4 i_clk = ~i_clk;
  mif_src_model #(.N(16)) SRC (.i_clk(i_clk), .o_val(src));
  mif_top #(.N_SRC(16)) DUT (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_normalized_input_value(src), .o_out(o_out));

  function automatic logic [31:0] cfg(input int op, input int inv,
                                      input int s);
    return {16'h0, 4'(op), 3'h0, 1'(inv), 3'h0, 5'(s)};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] idx, input logic [31:0] d,
                    input logic inst = 1'b0);
    i_addr <= {3'h0, inst, idx};
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
    @(posedge i_clk);
  endtask
  task automatic chk_out(input mif_val_t v, input logic av,
                         input logic inst = 1'b0);
    repeat (3) @(posedge i_clk);
    #1;
    chk("value", o_out[inst].normalized_output_value, v);
    chk("avail", {31'h0, o_out[inst].avail}, {31'h0, av});
    @(posedge i_clk);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic t_reset;
    rd(8'h00, rv);
    chk("cfg1", rv, 32'h0);
    rd(8'h17, rv);
    chk("scale4", rv, ONE);
    rd(8'h18, rv);
    chk("oscale", rv, ONE);
    chk_out(32'sh0, 1'b0);
    $display("reset defaults done");
  endtask
  task automatic t_add;
    SRC.put(0, 32'sh0040_0000);
    SRC.put(1, HALF);
    wr(REG_CFG0, cfg(0, 0, 1));
    wr(REG_CFG0 + 4'h1, cfg(0, 0, 2));
    chk_out(32'sh00c0_0000, 1'b1);
    rd({4'h0, REG_YN}, rv);
    chk("yn", rv, 32'h00c0_0000);
    rd({4'h0, REG_AVAIL}, rv);
    chk("avail_reg", rv, 32'h1);
    rd(8'h0b, rv);
    chk("unmapped", rv, 32'h0);
    chk_out(32'sh0, 1'b0, 1'b1);
    $display("plain addition done");
  endtask
  task automatic t_ops;
    for (int k = 0; k < 13; k++) begin
      wr(REG_CFG0 + 4'h1, cfg(k, 0, 2));
      chk_out(exp_op[k], 1'b1);
    end
    $display("operation table done");
  endtask
  task automatic t_edges;
    SRC.put(0, HALF + DELTA);
    wr(REG_CFG0 + 4'h1, cfg(10, 0, 2));
    chk_out(ONE, 1'b1);
    SRC.put(0, HALF + DELTA + 32'sh1);
    chk_out(32'sh0, 1'b1);
    SRC.put(0, HALF);
    SRC.put(1, HALF - 32'sh1);
    wr(REG_CFG0 + 4'h1, cfg(6, 0, 2));
    chk_out(32'sh0, 1'b1);
    SRC.put(0, 32'sh0);
    SRC.put(1, 32'sh0);
    wr(REG_CFG0 + 4'h1, cfg(2, 0, 2));
    chk_out(ONE, 1'b1);
    $display("tolerance and guards done");
  endtask
  task automatic t_chain;
    SRC.put(0, 32'sh0040_0000);
    SRC.put(1, HALF);
    SRC.put(2, 32'sh0040_0000);
    wr(REG_CFG0, cfg(0, 1, 1));
    wr(REG_CFG0 + 4'h1, cfg(0, 0, 2));
    wr(REG_SCALE0 + 4'h1, 32'h0080_0000);
    wr(REG_CFG0 + 4'h2, cfg(1, 0, 0));
    wr(REG_CFG0 + 4'h3, cfg(1, 0, 3));
    wr(REG_OSCALE, 32'h0200_0000);
    chk_out(32'sh0080_0000, 1'b1);
    wr(REG_OSCALE, 32'hff00_0000);
    chk_out(32'sh0, 1'b1);
    wr(REG_OSCALE, 32'h0800_0000);
    chk_out(ONE, 1'b1);
    wr(REG_CFG0 + 4'h1, cfg(0, 0, 0));
    chk_out(32'sh0, 1'b0);
    $display("chain, invert and clip done");
  endtask
  task automatic t_inst1;
    wr(REG_CFG0, cfg(0, 0, 2), 1'b1);
    wr(REG_CFG0 + 4'h1, cfg(1, 0, 3), 1'b1);
    wr(REG_CFG0 + 4'h2, cfg(2, 0, 1), 1'b1);
    wr(REG_CFG0 + 4'h3, cfg(0, 0, 1), 1'b1);
    chk_out(32'sh00c0_0000, 1'b1, 1'b1);
    chk_out(32'sh0, 1'b0);
    rd(8'h19, rv);
    chk("yn1", rv, 32'h00c0_0000);
    rd(8'h1a, rv);
    chk("avail1", rv, 32'h1);
    wr(REG_CFG0, cfg(0, 0, 0), 1'b1);
    chk_out(32'sh0, 1'b0, 1'b1);
    $display("second instance done");
  endtask

  initial begin
    #40000;
    failures++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    t_reset();
    t_add();
    t_ops();
    t_edges();
    t_chain();
    t_inst1();
    print_verdict();
  end
endmodule
`default_nettype wire
